// >>> verilog/cp_seq_regs.svh
// Purpose: named constants for the coprocessor transfer sequencer
// Assumes: word accesses, 32-bit addresses
// Notes: offsets are relative to the instruction address, except the word step OFS_STEP
`ifndef CP_SEQ_REGS_SVH
`define CP_SEQ_REGS_SVH
`define SIZE_WORD 2'h2
`define SIZE_UNUSED 2'h0
`define SIZE_HALF 2'h1
`define OFS_PC8 32'h0000_0008
`define OFS_PC12 32'h0000_000C
`define OFS_STEP 32'h0000_0004
`define OFS_NEXT_NARROW 32'h0000_0004
`define MODE_UNDEF 5'h04
`define REG_ZERO 4'h0
`endif

// >>> verilog/cp_seq_pkg.sv
// Purpose: types for the coprocessor transfer sequencer
// Assumes: nothing beyond the constants header
// Notes: one-hot state codes written out
package cp_seq_pkg;
   typedef enum logic [1:0] {OP_MEM_STORE = 2'h0, OP_REG_LOAD = 2'h1, OP_REG_STORE = 2'h2, OP_OTHER = 2'h3} op_t;
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_OFFER = 8'h02,
      ST_BUSY = 8'h04,
      ST_XFER = 8'h08,
      ST_WRITEBACK = 8'h10,
      ST_TRAP_INT = 8'h20,
      ST_TRAP_F1 = 8'h40,
      ST_TRAP_F2 = 8'h80
   } state_t;
endpackage : cp_seq_pkg

// >>> verilog/cp_bus_if.sv
// Purpose: bus-cycle bundle from the sequencer to its output stage
// Assumes: single clock
// Notes: combinational values; the output stage registers them
`timescale 1ns/1ps
interface cp_bus_if;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic [1:0] size;
   logic wnr;
   logic mreq_n;
   logic burst;
   logic fetch_n;
   logic cpi_n;
   logic [4:0] mode;
   logic tflag;
   logic user_n;
   modport src (output addr, wdata, size, wnr, mreq_n, burst, fetch_n, cpi_n, mode, tflag, user_n);
   modport dst (input addr, wdata, size, wnr, mreq_n, burst, fetch_n, cpi_n, mode, tflag, user_n);
endinterface : cp_bus_if

// >>> verilog/cp_bus_reg.sv
// Purpose: registers every bus output of the sequencer
// Assumes: rstn asynchronous, active low
// Notes: idle values hold the bus quiet
`timescale 1ns/1ps
`include "cp_seq_regs.svh"
module cp_bus_reg (
   input wire logic clk,
   input wire logic rstn,
   cp_bus_if.dst nx,
   output logic [31:0] address,
   output logic [31:0] write_data,
   output logic [1:0] access_size,
   output logic write_not_read,
   output logic mem_request_n,
   output logic burst_continue,
   output logic instr_fetch_n,
   output logic coproc_instr_n,
   output logic [4:0] proc_mode,
   output logic instr_set_flag,
   output logic user_access_n
);
   // Pure pipeline register, quiet bus during reset
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         address <= 32'h0000_0000;
         write_data <= 32'h0000_0000;
         access_size <= `SIZE_UNUSED;
         write_not_read <= 1'b0;
         mem_request_n <= 1'b1;
         burst_continue <= 1'b0;
         instr_fetch_n <= 1'b1;
         coproc_instr_n <= 1'b1;
         proc_mode <= 5'h00;
         instr_set_flag <= 1'b0;
         user_access_n <= 1'b0;
      end
      else
      begin
         address <= nx.addr;
         write_data <= nx.wdata;
         access_size <= nx.size;
         write_not_read <= nx.wnr;
         mem_request_n <= nx.mreq_n;
         burst_continue <= nx.burst;
         instr_fetch_n <= nx.fetch_n;
         coproc_instr_n <= nx.cpi_n;
         proc_mode <= nx.mode;
         instr_set_flag <= nx.tflag;
         user_access_n <= nx.user_n;
      end
   end
endmodule : cp_bus_reg

// >>> verilog/coproc_transfer_sequencer.sv
// Purpose: sequences coprocessor handshake bus cycles for transfers, register moves and the undefined trap
// Assumes: handshake inputs synchronous to clk; coprocessor ends transfers itself
// Notes: outputs except busy lag the state by one register stage
// Summary of operation
// - Coprocessor-to-memory transfer runs like memory-to-coprocessor, but writes during data cycles.
// - Word accesses, burst high until final cycle; coprocessor raises both lines last.
// - Busy cycles at pc+8, request off, not fetching, offer held, until wait low.
// - Register load from coprocessor moves exactly one word with the same busy-wait.
// - Received word written to destination register in third cycle after busy.
// - Final write-back cycle may merge with next prefetch as nonsequential cycle.
// - Load presents pc+12, no request, read, while coprocessor gives word; then burst.
// - Store to coprocessor is the load sequence without its final cycle.
// - Store data cycle drives register on data bus, write, pc+12, request, offer off.
// - Instructions nobody can execute, undefined ones included, take the undefined trap.
// - Trap: offer, fetch request at the offer address, then fetch trap address and next, mode 00100.
// - No coprocessor instruction is offered in compressed 16-bit state.
`timescale 1ns/1ps
`include "cp_seq_regs.svh"
module coproc_transfer_sequencer
   import cp_seq_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic start,
   input wire cp_seq_pkg::op_t op,
   input wire logic undefined_op,
   input wire logic narrow_state,
   input wire logic [31:0] pc,
   input wire logic [31:0] xfer_base,
   input wire logic [31:0] trap_vector,
   input wire logic [31:0] src_reg_value,
   input wire logic [3:0] dest_reg,
   input wire logic [4:0] cur_mode,
   input wire logic cur_user_n,
   input wire logic coproc_absent,
   input wire logic coproc_wait,
   input wire logic [31:0] coproc_word,
   output logic [31:0] address,
   output logic [31:0] write_data,
   output logic [1:0] access_size,
   output logic write_not_read,
   output logic mem_request_n,
   output logic burst_continue,
   output logic instr_fetch_n,
   output logic coproc_instr_n,
   output logic [4:0] proc_mode,
   output logic instr_set_flag,
   output logic user_access_n,
   output logic reg_we,
   output logic [3:0] reg_waddr,
   output logic [31:0] reg_wdata,
   output logic merge_prefetch,
   output logic busy,
   output logic trap_taken
);
   import cp_seq_pkg::*;

   cp_bus_if nx ();
   state_t state_r, state_nxt;
   op_t op_r, op_nxt;
   logic [31:0] pc_r, pc_nxt;
   logic [31:0] addr_r, addr_nxt;
   logic [31:0] vec_r, vec_nxt;
   logic [31:0] src_r, src_nxt;
   logic [31:0] word_r, word_nxt;
   logic [3:0] dest_r, dest_nxt;
   logic [4:0] mode_r, mode_nxt;
   logic user_r, user_nxt;
   logic narrow_r, narrow_nxt;
   logic we_r, we_nxt;
   logic merge_r, merge_nxt;
   logic trap_r, trap_nxt;
   logic force_r, force_nxt;
   logic busy_r, busy_nxt;
   logic accept;
   logic last;

   // Handshake decode: accepted when wait low; last when both high
   assign accept = !coproc_wait;
   assign last = coproc_absent && coproc_wait;

   // Sequencer next state and per-cycle bus values
   always_comb
   begin
      state_nxt = state_r;
      op_nxt = op_r;
      pc_nxt = pc_r;
      addr_nxt = addr_r;
      vec_nxt = vec_r;
      src_nxt = src_r;
      word_nxt = word_r;
      dest_nxt = dest_r;
      mode_nxt = mode_r;
      user_nxt = user_r;
      narrow_nxt = narrow_r;
      we_nxt = 1'b0;
      merge_nxt = 1'b0;
      trap_nxt = 1'b0;
      force_nxt = force_r;
      nx.addr = pc_r + (narrow_r ? `OFS_NEXT_NARROW : `OFS_PC8);
      nx.wdata = 32'h0000_0000;
      nx.size = narrow_r ? `SIZE_HALF : `SIZE_WORD;
      nx.wnr = 1'b0;
      nx.mreq_n = 1'b1;
      nx.burst = 1'b0;
      nx.fetch_n = 1'b1;
      nx.cpi_n = 1'b1;
      nx.mode = mode_r;
      nx.tflag = narrow_r;
      nx.user_n = user_r;
      case (state_r)
         ST_IDLE:
         begin
            if (start)
            begin
               op_nxt = op;
               pc_nxt = pc;
               addr_nxt = xfer_base;
               vec_nxt = trap_vector;
               src_nxt = src_reg_value;
               dest_nxt = dest_reg;
               mode_nxt = cur_mode;
               user_nxt = cur_user_n;
               narrow_nxt = narrow_state;
               // Unexecutable ops still spend the offer cycle, then trap whatever the handshake says
               force_nxt = undefined_op || narrow_state || (op == OP_OTHER);
               state_nxt = ST_OFFER;
            end
         end
         ST_OFFER, ST_BUSY:
         begin
            // Offer at pc+8; first cycle is also the opcode fetch; no offer in narrow state
            nx.cpi_n = narrow_r;
            nx.fetch_n = (state_r == ST_BUSY);
            if (force_r)
               state_nxt = ST_TRAP_INT;
            else if (accept)
            begin
               // Memory transfer requests at once; register moves announce a sequential cycle
               nx.mreq_n = (op_r != OP_MEM_STORE);
               nx.burst = (op_r != OP_MEM_STORE);
               state_nxt = ST_XFER;
            end
            else if (coproc_absent)
               state_nxt = ST_TRAP_INT;
            else
               state_nxt = ST_BUSY;
         end
         ST_XFER:
         begin
            case (op_r)
               OP_MEM_STORE:
               begin
                  // Coprocessor drives data, core writes memory
                  nx.addr = addr_r;
                  nx.wnr = 1'b1;
                  nx.mreq_n = 1'b0;
                  nx.burst = !last;
                  addr_nxt = addr_r + `OFS_STEP;
                  if (last)
                     state_nxt = ST_IDLE;
               end
               OP_REG_LOAD:
               begin
                  // Single word captured; no memory request
                  nx.addr = pc_r + `OFS_PC12;
                  word_nxt = coproc_word;
                  state_nxt = ST_WRITEBACK;
               end
               default:
               begin
                  // Store: register value out, request on, single cycle
                  nx.addr = pc_r + `OFS_PC12;
                  nx.wdata = src_r;
                  nx.wnr = 1'b1;
                  nx.mreq_n = 1'b0;
                  state_nxt = ST_IDLE;
               end
            endcase
         end
         ST_WRITEBACK:
         begin
            // Third cycle: register write merged with the N-cycle prefetch
            nx.addr = pc_r + `OFS_PC12;
            nx.mreq_n = 1'b0;
            nx.burst = 1'b1;
            we_nxt = 1'b1;
            merge_nxt = 1'b1;
            state_nxt = ST_IDLE;
         end
         ST_TRAP_INT:
         begin
            // Fetch request cycle, offer withdrawn; defaults repeat the cycle 1 address and size
            nx.fetch_n = 1'b0;
            nx.mreq_n = 1'b0;
            state_nxt = ST_TRAP_F1;
         end
         ST_TRAP_F1, ST_TRAP_F2:
         begin
            nx.addr = (state_r == ST_TRAP_F1) ? vec_r : vec_r + `OFS_STEP;
            nx.mreq_n = 1'b0;
            nx.burst = 1'b1;
            nx.fetch_n = 1'b0;
            nx.mode = `MODE_UNDEF;
            nx.tflag = 1'b0;
            nx.user_n = 1'b1;
            trap_nxt = (state_r == ST_TRAP_F1);
            state_nxt = (state_r == ST_TRAP_F1) ? ST_TRAP_F2 : ST_IDLE;
            if (state_r == ST_TRAP_F2)
            begin
               mode_nxt = `MODE_UNDEF;
               narrow_nxt = 1'b0;
               user_nxt = 1'b1;
            end
         end
         default:
            state_nxt = ST_IDLE;
      endcase
      busy_nxt = (state_nxt != ST_IDLE);
   end

   // State registers only
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r <= ST_IDLE;
         op_r <= OP_MEM_STORE;
         pc_r <= 32'h0000_0000;
         addr_r <= 32'h0000_0000;
         vec_r <= 32'h0000_0000;
         src_r <= 32'h0000_0000;
         word_r <= 32'h0000_0000;
         dest_r <= `REG_ZERO;
         mode_r <= 5'h00;
         user_r <= 1'b0;
         narrow_r <= 1'b0;
         we_r <= 1'b0;
         merge_r <= 1'b0;
         trap_r <= 1'b0;
         force_r <= 1'b0;
         busy_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         op_r <= op_nxt;
         pc_r <= pc_nxt;
         addr_r <= addr_nxt;
         vec_r <= vec_nxt;
         src_r <= src_nxt;
         word_r <= word_nxt;
         dest_r <= dest_nxt;
         mode_r <= mode_nxt;
         user_r <= user_nxt;
         narrow_r <= narrow_nxt;
         we_r <= we_nxt;
         merge_r <= merge_nxt;
         trap_r <= trap_nxt;
         force_r <= force_nxt;
         busy_r <= busy_nxt;
      end
   end

   // Register-file write and status straight from flip-flops
   assign reg_we = we_r;
   assign reg_waddr = dest_r;
   assign reg_wdata = word_r;
   assign merge_prefetch = merge_r;
   assign trap_taken = trap_r;
   assign busy = busy_r;

   // Output stage registers the bus cycle
   cp_bus_reg u_bus (
      .clk(clk),
      .rstn(rstn),
      .nx(nx),
      .address(address),
      .write_data(write_data),
      .access_size(access_size),
      .write_not_read(write_not_read),
      .mem_request_n(mem_request_n),
      .burst_continue(burst_continue),
      .instr_fetch_n(instr_fetch_n),
      .coproc_instr_n(coproc_instr_n),
      .proc_mode(proc_mode),
      .instr_set_flag(instr_set_flag),
      .user_access_n(user_access_n)
   );
endmodule : coproc_transfer_sequencer

// >>> bench/coproc_seq_checker.sv
// Purpose: port assertions for the coprocessor transfer sequencer
// Assumes: one clock, rstn async active low
// Notes: watches design outputs plus the start, undefined_op and narrow_state inputs
`timescale 1ns/1ps
module coproc_seq_checker (
   input wire logic clk,
   input wire logic rstn,
   input wire logic start,
   input wire logic undefined_op,
   input wire logic narrow_state,
   input wire logic busy,
   input wire logic [31:0] address,
   input wire logic [1:0] access_size,
   input wire logic write_not_read,
   input wire logic mem_request_n,
   input wire logic burst_continue,
   input wire logic instr_fetch_n,
   input wire logic coproc_instr_n,
   input wire logic [4:0] proc_mode,
   input wire logic instr_set_flag,
   input wire logic user_access_n,
   input wire logic reg_we,
   input wire logic merge_prefetch,
   input wire logic trap_taken
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Trap fetches: fixed mode, wide state, privileged, after offer and a cycle with offer withdrawn
   a_trap_mode: assert property (trap_taken |-> proc_mode == 5'h04 && !instr_set_flag && user_access_n)
      else $error("trap mode wrong");
   a_trap_order: assert property (trap_taken |-> $past(coproc_instr_n)
      && ($past(coproc_instr_n, 2) == $past(instr_set_flag, 2)) && ($past(address) == $past(address, 2))
      && !mem_request_n && burst_continue
      ##1 address == $past(address) + 32'h4 && !mem_request_n && burst_continue)
      else $error("trap cycle order wrong");
   a_narrow_no_offer: assert property (instr_set_flag |-> coproc_instr_n)
      else $error("offer in narrow state");
   a_trap_bound: assert property (start && !busy && (undefined_op || narrow_state) |-> ##[2:8] trap_taken)
      else $error("no trap for unexecutable op");
   a_busy_hold: assert property (!coproc_instr_n && instr_fetch_n |-> access_size == 2'h2
      && address == $past(address))
      else $error("busy cycle moved");
   a_offer_fetch: assert property ($fell(coproc_instr_n) |-> !instr_fetch_n)
      else $error("offer without fetch");
   a_write_word: assert property (write_not_read && !mem_request_n |-> access_size == 2'h2
      && coproc_instr_n && instr_fetch_n)
      else $error("write cycle wrong");
   a_burst_next: assert property (write_not_read && !mem_request_n && burst_continue |=> write_not_read
      && !mem_request_n && address == $past(address) + 32'h4)
      else $error("burst broken");
   a_load_read: assert property (!coproc_instr_n ##1 coproc_instr_n && mem_request_n |-> !write_not_read
      && address == $past(address) + 32'h4 ##1 !mem_request_n && burst_continue && address == $past(address))
      else $error("load data cycle wrong");
   a_merge_we: assert property (reg_we |-> merge_prefetch)
      else $error("write-back not merged");
   a_idle_quiet: assert property (!busy && !$past(busy) |-> coproc_instr_n)
      else $error("offer while idle");
endmodule : coproc_seq_checker

// >>> bench/coproc_model.sv
// Purpose: behavioural coprocessor on the handshake lines
// Assumes: sequence length follows busy of the core side
// Notes: waits n_busy cycles, then moves n_words words
`timescale 1ns/1ps
module coproc_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic busy,
   input wire logic absent_mode,
   input wire logic [7:0] n_busy,
   input wire logic [7:0] n_words,
   input wire logic [31:0] word_val,
   output logic coproc_absent,
   output logic coproc_wait,
   output logic [31:0] coproc_word
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   // Cycle index inside one sequence
   always_comb cnt_nxt = busy ? cnt_r + 8'h01 : 8'h00;
   always_ff @(posedge clk or negedge rstn)
      if (!rstn) cnt_r <= 8'h00;
      else cnt_r <= cnt_nxt;
   // Handshake; idle word is inverted so a stale copy is never read back
   always_comb
   begin
      coproc_absent = 1'b1;
      coproc_wait = 1'b1;
      coproc_word = ~word_val;
      if (busy && !absent_mode)
      begin
         if (cnt_r < n_busy)
            coproc_absent = 1'b0;
         else if (cnt_r < n_busy + n_words)
         begin
            coproc_absent = 1'b0;
            coproc_wait = 1'b0;
            if (cnt_r != n_busy) coproc_word = word_val;
         end
         else if (cnt_r == n_busy + n_words)
            coproc_word = word_val;
      end
   end
endmodule : coproc_model

// >>> bench/coproc_transfer_sequencer_tb.sv
// Purpose: directed tests of the coprocessor transfer sequencer
// Assumes: 125 MHz clock, async active-low reset
// Notes: each run counts bus cycles of one sequence
`timescale 1ns/1ps
module coproc_transfer_sequencer_tb;
   import cp_seq_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, start = 1'b0, undefined_op = 1'b0, narrow_state = 1'b0, absent_mode = 1'b0;
   op_t op = OP_MEM_STORE;
   logic [31:0] pc = 32'h0000_1000, xfer_base = 32'h0000_8000, trap_vector = 32'h0000_0004;
   logic [31:0] src_reg_value = 32'h1234_5678, word_val, address, write_data, reg_wdata, coproc_word;
   logic [31:0] wa, wd, rd, ta;
   logic [7:0] n_busy = 8'h00, n_words = 8'h01;
   logic [3:0] dest_reg = 4'h9, reg_waddr, ra;
   logic [4:0] cur_mode = 5'h13, proc_mode;
   logic [1:0] access_size;
   logic cur_user_n = 1'b1, coproc_absent, coproc_wait, write_not_read, mem_request_n, burst_continue;
   logic instr_fetch_n, coproc_instr_n, instr_set_flag, user_access_n, reg_we, merge_prefetch, busy, trap_taken;
   int n_fail = 0, num_checks = 0, wr, bw, we, tr, nof;
   assign word_val = pc ^ 32'hA5A5_5A5A;
   always #4 clk = ~clk;
   coproc_transfer_sequencer DUT (.clk, .rstn, .start, .op, .undefined_op, .narrow_state, .pc, .xfer_base,
      .trap_vector, .src_reg_value, .dest_reg, .cur_mode, .cur_user_n, .coproc_absent, .coproc_wait,
      .coproc_word, .address, .write_data, .access_size, .write_not_read, .mem_request_n, .burst_continue,
      .instr_fetch_n, .coproc_instr_n, .proc_mode, .instr_set_flag, .user_access_n, .reg_we, .reg_waddr,
      .reg_wdata, .merge_prefetch, .busy, .trap_taken);
   coproc_model cop (.clk, .rstn, .busy, .absent_mode, .n_busy, .n_words, .word_val, .coproc_absent,
      .coproc_wait, .coproc_word);
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish
   // One sequence; counts write, busy-wait, write-back and trap cycles
   task run(input string nm, input op_t o, input logic u, input logic nr, input logic ab, input logic [7:0] nb,
      input logic [7:0] nw);
      int tail;
      tail = 0;
      wr = 0;
      bw = 0;
      we = 0;
      tr = 0;
      nof = 0;
      @(posedge clk);
      op <= o;
      undefined_op <= u;
      narrow_state <= nr;
      absent_mode <= ab;
      n_busy <= nb;
      n_words <= nw;
      pc <= pc + 32'h0000_0100;
      xfer_base <= xfer_base + 32'h0000_0040;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      for (int i = 0; i < 60 && tail < 3; i++)
      begin
         @(posedge clk);
         #1;
         if (write_not_read && !mem_request_n)
         begin
            wr++;
            wa = address;
            wd = write_data;
         end
         if (!coproc_instr_n && instr_fetch_n) bw++;
         if (!coproc_instr_n) nof++;
         if (reg_we)
         begin
            we++;
            rd = reg_wdata;
            ra = reg_waddr;
         end
         if (trap_taken)
         begin
            tr++;
            ta = address;
         end
         tail = busy ? 0 : tail + 1;
      end
      $display("test %s done", nm);
   endtask : run
   // Watchdog cuts a hang short
   initial
   begin
      #(8 * 4000);
      n_fail++;
      tally_and_finish();
   end
   // Main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      run("mem_store_burst", OP_MEM_STORE, 0, 0, 0, 8'h02, 8'h03);
      chk("writes", wr, 3);
      chk("last_addr", wa, xfer_base + 32'h8);
      chk("busy_cycles", bw, 2);
      run("mem_store_one", OP_MEM_STORE, 0, 0, 0, 8'h00, 8'h01);
      chk("writes", wr, 1);
      chk("addr", wa, xfer_base);
      run("load_ready", OP_REG_LOAD, 0, 0, 0, 8'h00, 8'h01);
      chk("wb_count", we, 1);
      chk("wb_data", rd, word_val);
      chk("wb_reg", ra, dest_reg);
      chk("writes", wr, 0);
      run("load_wait", OP_REG_LOAD, 0, 0, 0, 8'h03, 8'h01);
      chk("busy_cycles", bw, 3);
      chk("wb_data", rd, word_val);
      run("store", OP_REG_STORE, 0, 0, 0, 8'h01, 8'h01);
      chk("writes", wr, 1);
      chk("addr", wa, pc + 32'hC);
      chk("data", wd, src_reg_value);
      chk("wb_count", we, 0);
      run("absent", OP_REG_LOAD, 0, 0, 1, 8'h00, 8'h01);
      chk("traps", tr, 1);
      chk("trap_addr", ta, trap_vector);
      chk("offers", nof, 1);
      chk("wb_count", we, 0);
      run("undefined", OP_MEM_STORE, 1, 0, 1, 8'h00, 8'h01);
      chk("traps", tr, 1);
      chk("writes", wr, 0);
      chk("offers", nof, 1);
      chk("trap_addr", ta, trap_vector);
      run("other_op", OP_OTHER, 0, 0, 1, 8'h00, 8'h01);
      chk("traps", tr, 1);
      chk("wb_count", we, 0);
      chk("offers", nof, 1);
      run("narrow", OP_REG_STORE, 0, 1, 1, 8'h00, 8'h01);
      chk("traps", tr, 1);
      chk("writes", wr, 0);
      chk("offers", nof, 0);
      tally_and_finish();
   end
endmodule : coproc_transfer_sequencer_tb
bind coproc_transfer_sequencer coproc_seq_checker chk_i (.clk, .rstn, .start, .undefined_op, .narrow_state,
   .busy, .address, .access_size, .write_not_read, .mem_request_n, .burst_continue, .instr_fetch_n,
   .coproc_instr_n, .proc_mode, .instr_set_flag, .user_access_n, .reg_we, .merge_prefetch, .trap_taken);
